// File: src/t16_timer.v
// 16-bit timer/counter with clear-on-compare and fast pwm waveform modes
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "t16_defs.vh"

// How it works
// - clear-on-compare resets count at match with compare a (4) or top register (12).
// - clear-on-compare sets compare a or capture flag when count reaches top.
// - clear-on-compare top unbuffered; top below count means wrap through 0xffff first.
// - action 1 in clear-on-compare toggles output a each match; pin needs direction out.
// - toggled output frequency is clock over 2*N*(1+top).
// - clear-on-compare sets overflow flag only when count passes 0xffff to zero.
// - selects 5,6,7,14,15 count single slope from zero to top then restart.
// - fast pwm top is 0xff, 0x1ff, 0x3ff, top register or compare a.
// - fast pwm non-inverting sets on match, clears at wrap; inverting the opposite.
// - action 2 is non-inverted pwm, 3 inverted; pin shows it only when output.
// - fast pwm sets overflow at top, plus compare a or capture flag when variable.
// - fixed top modes zero compare bits above resolution on compare writes.
// - top register acts at once; set below count, counter runs to 0xffff first.
// - fast pwm compare a writes go to a buffer, copied in at top.
// - fast pwm period is N*(1+top) clock cycles.
// - compare 0 gives a one-cycle spike; compare equal top gives constant level.
// - select 15 with action 1 toggles output a for a square wave.
// - a channel flag sets on each unblocked timer tick where count equals its active compare value.
// - a count write suppresses every compare match in the next timer tick.
// - action 0 leaves the output register alone and restores the port function.
// - high byte write fills a temporary latch; low byte write moves both at once.
module t16_timer (
	input wire clock,
	input wire rst,
	input wire [3:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	output reg [7:0] reg_rdata,
	input wire [1:0] port_level,
	output reg [1:0] compare_pin_out,
	output reg [1:0] compare_pin_oe_n
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	reg [3:0] waveform_select_q;
	reg [5:0] action_q;
	reg [2:0] prescale_q;
	reg [3:0] flags_q;
	reg [3:0] flags_d;
	reg [15:0] timer_count_q;
	reg [15:0] timer_count_d;
	reg [15:0] compare_value_q [0:1];
	reg [15:0] compare_buf_q [0:1];
	reg [15:0] capture_top_value_q;
	reg [7:0] temp_q;
	reg [9:0] pre_cnt_q;
	reg blocked_q;
	reg [1:0] compare_output_q;
	reg [15:0] top;
	reg ctc;
	reg fast;
	reg fixed_top;
	reg tick;
	reg [9:0] div;
	wire at_top;
	wire count_wr;
	wire [15:0] wr_word;
	wire [1:0] match;

	assign wr_word = {temp_q, reg_wdata};
	assign count_wr = reg_write && (reg_addr == `T16_ADR_COUNT_LO);
	assign at_top = (timer_count_q == top);

	// ------------------------------------------------------------------
	// mode decode
	// ------------------------------------------------------------------
	always @* begin
		ctc = 1'b0;
		fast = 1'b0;
		fixed_top = 1'b0;
		case (waveform_select_q)
			`T16_WS_CTC_A: begin
				top = compare_value_q[0];
				ctc = 1'b1;
			end
			`T16_WS_CTC_TOP: begin
				top = capture_top_value_q;
				ctc = 1'b1;
			end
			`T16_WS_FAST8: begin
				top = `T16_TOP8;
				fast = 1'b1;
				fixed_top = 1'b1;
			end
			`T16_WS_FAST9: begin
				top = `T16_TOP9;
				fast = 1'b1;
				fixed_top = 1'b1;
			end
			`T16_WS_FAST10: begin
				top = `T16_TOP10;
				fast = 1'b1;
				fixed_top = 1'b1;
			end
			`T16_WS_FAST_TOP: begin
				top = capture_top_value_q;
				fast = 1'b1;
			end
			`T16_WS_FAST_A: begin
				top = compare_value_q[0];
				fast = 1'b1;
			end
			default: top = `T16_MAX;
		endcase
	end

	// ------------------------------------------------------------------
	// prescaler: select 0 stops, 1..5 divide by 1, 8, 64, 256, 1024
	// ------------------------------------------------------------------
	always @* begin
		case (prescale_q)
			3'h2: div = `T16_DIV8;
			3'h3: div = `T16_DIV64;
			3'h4: div = `T16_DIV256;
			3'h5: div = `T16_DIV1024;
			default: div = 10'h000;
		endcase
		tick = (prescale_q != 3'h0) && (prescale_q < 3'h6) && (pre_cnt_q >= div);
	end

	always @(posedge clock) begin
		if (rst || !tick) begin
			pre_cnt_q <= (rst || prescale_q == 3'h0) ? 10'h000 : pre_cnt_q + 10'h001;
		end else begin
			pre_cnt_q <= 10'h000;
		end
	end

	// ------------------------------------------------------------------
	// counter and flags
	// ------------------------------------------------------------------
	generate
		genvar ch;
		for (ch = 0; ch < 2; ch = ch + 1) begin : g_match
			assign match[ch] = (timer_count_q == compare_value_q[ch]) && !blocked_q;
		end
	endgenerate

	always @* begin
		timer_count_d = timer_count_q;
		flags_d = flags_q;
		if (reg_write && reg_addr == `T16_ADR_FLAGS) begin
			flags_d = flags_q & ~reg_wdata[3:0];
		end
		if (tick) begin
			if ((ctc || fast) && at_top && !blocked_q) begin
				timer_count_d = `T16_ZERO;
			end else begin
				timer_count_d = timer_count_q + 16'h0001;
			end
			if (fast ? (at_top && !blocked_q) : (timer_count_q == `T16_MAX)) begin
				flags_d[`T16_FLAG_OVF] = 1'b1;
			end
			if (match[0]) begin
				flags_d[`T16_FLAG_CMPA] = 1'b1;
			end
			if (match[1]) begin
				flags_d[`T16_FLAG_CMPB] = 1'b1;
			end
			if ((waveform_select_q == `T16_WS_CTC_TOP || waveform_select_q == `T16_WS_FAST_TOP)
				&& at_top && !blocked_q) begin
				flags_d[`T16_FLAG_CAP] = 1'b1;
			end
		end
		if (count_wr) begin
			timer_count_d = wr_word;
		end
	end

	always @(posedge clock) begin
		if (rst) begin
			timer_count_q <= `T16_ZERO;
			flags_q <= 4'h0;
			blocked_q <= 1'b0;
		end else begin
			timer_count_q <= timer_count_d;
			flags_q <= flags_d;
			if (count_wr) begin
				blocked_q <= 1'b1;
			end else if (tick) begin
				blocked_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// compare channels: buffer, active value, waveform register, pin
	// ------------------------------------------------------------------
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
			wire wr_lo;
			wire [1:0] act;
			wire [15:0] masked;
			assign wr_lo = reg_write && (reg_addr == `T16_ADR_CMPA_LO + 4'h2 * ch);
			assign act = action_q[2 * ch + 1:2 * ch];
			assign masked = fixed_top ? (wr_word & top) : wr_word;

			always @(posedge clock) begin
				if (rst) begin
					compare_buf_q[ch] <= `T16_ZERO;
					compare_value_q[ch] <= `T16_ZERO;
				end else begin
					if (wr_lo) begin
						compare_buf_q[ch] <= masked;
					end
					if (wr_lo && !fast) begin
						compare_value_q[ch] <= masked;
					end else if (fast && tick && at_top && !blocked_q) begin
						compare_value_q[ch] <= compare_buf_q[ch];
					end
				end
			end

			always @(posedge clock) begin
				if (rst) begin
					compare_output_q[ch] <= 1'b0;
				end else if (tick && act != 2'h0) begin
					if (fast) begin
						if (act == 2'h1) begin
							if (ch == 0 && waveform_select_q == `T16_WS_FAST_A && match[ch]) begin
								compare_output_q[ch] <= ~compare_output_q[ch];
							end
						end else if (match[ch]) begin
							compare_output_q[ch] <= (act == 2'h2);
						end else if (at_top && !blocked_q) begin
							compare_output_q[ch] <= (act == 2'h3);
						end
					end else if (match[ch]) begin
						if (act == 2'h1) begin
							compare_output_q[ch] <= ~compare_output_q[ch];
						end else begin
							compare_output_q[ch] <= (act == 2'h3);
						end
					end
				end
			end

			always @(posedge clock) begin
				if (rst) begin
					compare_pin_out[ch] <= 1'b0;
					compare_pin_oe_n[ch] <= 1'b1;
				end else begin
					compare_pin_out[ch] <= (act != 2'h0) ? compare_output_q[ch] : port_level[ch];
					compare_pin_oe_n[ch] <= ~action_q[`T16_ACT_DIR_A + ch];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------------
	// register port
	// ------------------------------------------------------------------
	always @(posedge clock) begin
		if (rst) begin
			waveform_select_q <= 4'h0;
			action_q <= 6'h00;
			prescale_q <= 3'h0;
			temp_q <= 8'h00;
			capture_top_value_q <= `T16_TOP_RESET;
		end else if (reg_write) begin
			if (reg_addr == `T16_ADR_MODE) begin
				waveform_select_q <= reg_wdata[3:0];
			end else if (reg_addr == `T16_ADR_ACTION) begin
				action_q <= reg_wdata[5:0];
			end else if (reg_addr == `T16_ADR_PRESCALE) begin
				prescale_q <= reg_wdata[2:0];
			end else if (reg_addr == `T16_ADR_COUNT_HI || reg_addr == `T16_ADR_CMPA_HI
				|| reg_addr == `T16_ADR_CMPB_HI || reg_addr == `T16_ADR_TOP_HI) begin
				temp_q <= reg_wdata;
			end else if (reg_addr == `T16_ADR_TOP_LO) begin
				capture_top_value_q <= wr_word;
			end
		end
	end

	always @(posedge clock) begin
		if (rst || !reg_read) begin
			reg_rdata <= 8'h00;
		end else if (reg_addr == `T16_ADR_MODE) begin
			reg_rdata <= {4'h0, waveform_select_q};
		end else if (reg_addr == `T16_ADR_ACTION) begin
			reg_rdata <= {2'h0, action_q};
		end else if (reg_addr == `T16_ADR_PRESCALE) begin
			reg_rdata <= {5'h00, prescale_q};
		end else if (reg_addr == `T16_ADR_FLAGS) begin
			reg_rdata <= {2'h0, compare_output_q, flags_q};
		end else if (reg_addr == `T16_ADR_COUNT_LO) begin
			reg_rdata <= timer_count_q[7:0];
		end else if (reg_addr == `T16_ADR_COUNT_HI) begin
			reg_rdata <= timer_count_q[15:8];
		end else if (reg_addr == `T16_ADR_CMPA_LO) begin
			reg_rdata <= compare_buf_q[0][7:0];
		end else if (reg_addr == `T16_ADR_CMPA_HI) begin
			reg_rdata <= compare_buf_q[0][15:8];
		end else if (reg_addr == `T16_ADR_CMPB_LO) begin
			reg_rdata <= compare_buf_q[1][7:0];
		end else if (reg_addr == `T16_ADR_CMPB_HI) begin
			reg_rdata <= compare_buf_q[1][15:8];
		end else if (reg_addr == `T16_ADR_TOP_LO) begin
			reg_rdata <= capture_top_value_q[7:0];
		end else if (reg_addr == `T16_ADR_TOP_HI) begin
			reg_rdata <= capture_top_value_q[15:8];
		end else begin
			reg_rdata <= 8'h00;
		end
	end

endmodule

// File: inc/t16_defs.vh
// constants for the 16-bit timer with clear-on-compare and fast pwm modes
`ifndef T16_DEFS_VH
`define T16_DEFS_VH

// ----------------------------------------------------------------------
// register offsets (byte registers on an 8-bit port)
// ----------------------------------------------------------------------
`define T16_ADR_MODE 4'h0
`define T16_ADR_ACTION 4'h1
`define T16_ADR_PRESCALE 4'h2
`define T16_ADR_FLAGS 4'h3
`define T16_ADR_COUNT_LO 4'h4
`define T16_ADR_COUNT_HI 4'h5
`define T16_ADR_CMPA_LO 4'h6
`define T16_ADR_CMPA_HI 4'h7
`define T16_ADR_CMPB_LO 4'h8
`define T16_ADR_CMPB_HI 4'h9
`define T16_ADR_TOP_LO 4'ha
`define T16_ADR_TOP_HI 4'hb

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define T16_FLAG_OVF 0
`define T16_FLAG_CMPA 1
`define T16_FLAG_CMPB 2
`define T16_FLAG_CAP 3
`define T16_ACT_DIR_A 4
`define T16_ACT_DIR_B 5

// ----------------------------------------------------------------------
// waveform select codes
// ----------------------------------------------------------------------
`define T16_WS_CTC_A 4'h4
`define T16_WS_FAST8 4'h5
`define T16_WS_FAST9 4'h6
`define T16_WS_FAST10 4'h7
`define T16_WS_CTC_TOP 4'hc
`define T16_WS_FAST_TOP 4'he
`define T16_WS_FAST_A 4'hf

// ----------------------------------------------------------------------
// counts and reset values
// ----------------------------------------------------------------------
`define T16_MAX 16'hffff
`define T16_TOP8 16'h00ff
`define T16_TOP9 16'h01ff
`define T16_TOP10 16'h03ff
`define T16_ZERO 16'h0000
`define T16_TOP_RESET 16'h0000
`define T16_DIV8 10'h007
`define T16_DIV64 10'h03f
`define T16_DIV256 10'h0ff
`define T16_DIV1024 10'h3ff

`endif

// File: verif/t16_timer_asserts.sv
// port checker for the 16-bit timer
`timescale 1ns/1ps
module t16_timer_asserts (
	input wire clock,
	input wire rst,
	input wire [3:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	input wire [7:0] reg_rdata,
	input wire [1:0] port_level,
	input wire [1:0] compare_pin_out,
	input wire [1:0] compare_pin_oe_n
);
	logic [5:0] act_q;
	logic [3:0] mode_q;
	// ----------------------------------------
	// shadow of mode and action registers
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			act_q <= 6'h00;
			mode_q <= 4'h0;
		end else if (reg_write && reg_addr == 4'h1) begin
			act_q <= reg_wdata[5:0];
		end else if (reg_write && reg_addr == 4'h0) begin
			mode_q <= reg_wdata[3:0];
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence s_mode_rd;
		reg_read && reg_addr == 4'h0;
	endsequence
	chk_mode_read: assert property (s_mode_rd |=> reg_rdata[3:0] == mode_q)
		else $error("mode read back wrong");
	chk_unmapped_read: assert property (reg_read && reg_addr > 4'hb |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	chk_rdata_idle: assert property (!reg_read |=> reg_rdata == 8'h00)
		else $error("read data outside read slot");
	chk_port_pass_a: assert property (act_q[1:0] == 2'b00 |=> compare_pin_out[0] == $past(port_level[0]))
		else $error("pin a not following port");
	chk_port_pass_b: assert property (act_q[3:2] == 2'b00 |=> compare_pin_out[1] == $past(port_level[1]))
		else $error("pin b not following port");
	chk_dir_a: assert property ($stable(act_q[4]) |-> compare_pin_oe_n[0] == !act_q[4])
		else $error("pin a enable wrong");
	chk_dir_b: assert property ($stable(act_q[5]) |-> compare_pin_oe_n[1] == !act_q[5])
		else $error("pin b enable wrong");
	chk_reset_pins: assert property (disable iff (1'b0) rst |=> compare_pin_oe_n == 2'b11 && compare_pin_out == 2'b00)
		else $error("pins not idle after reset");
endmodule

bind t16_timer t16_timer_asserts u_chk (.clock(clock), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.port_level(port_level), .compare_pin_out(compare_pin_out),
	.compare_pin_oe_n(compare_pin_oe_n));

// File: verif/t16_timer_tb.sv
// self-checking bench for the 16-bit timer
`timescale 1ns/1ps
module t16_timer_tb;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [1:0] port_level = 2'b00;
	wire [7:0] reg_rdata;
	wire [1:0] compare_pin_out;
	wire [1:0] compare_pin_oe_n;
	int n_fail = 0;
	int check_count = 0;
	int seed = 19;
	int m, h, l, k, n, d;
	logic [15:0] top, cmp;
	logic [7:0] v;
	logic inv;

	always #5 clock = ~clock;
	always @(posedge clock) port_level <= 2'($random(seed));

	t16_timer u_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.port_level(port_level), .compare_pin_out(compare_pin_out),
		.compare_pin_oe_n(compare_pin_oe_n));
	// ----------------------------------------
	// bus and check tasks
	// ----------------------------------------
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (e !== g) begin
			$display("MISMATCH %s expected %h seen %h", s, e, g);
			n_fail++;
		end
	endtask
	task automatic init;
		rst <= 1'b1;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] x);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= x;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	task automatic wr16(input logic [3:0] a, input logic [15:0] x);
		wr(a + 4'h1, x[15:8]);
		wr(a, x[7:0]);
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] x);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 x = reg_rdata;
	endtask
	// cycles the pin stays at one level, bounded
	task automatic run_len(input logic lv, output int c);
		c = 0;
		#1;
		while (compare_pin_out[0] === lv) begin
			@(posedge clock);
			#1 c++;
			if (c > 9000) begin
				n_fail++;
				give_verdict;
			end
		end
	endtask
	// skips the start-up periods, then one high and one low run
	task automatic meas;
		for (k = 0; k < 3; k++) run_len(k[0], h);
		run_len(1'b1, h);
		run_len(1'b0, l);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		init;
		for (k = 0; k < 13; k++) begin
			rd(k[3:0], v);
			chk("reset read", 16'h0000, {8'h00, v});
		end
		for (m = 0; m < 2; m++) begin
			init;
			n = $random(seed) & 15;
			wr(4'h0, m ? 8'h0f : 8'h04);
			wr16(4'h6, 16'(n));
			wr(4'h1, 8'h11);
			wr(4'h2, m ? 8'h02 : 8'h01);
			meas;
			d = (m ? 8 : 1) * (n + 1);
			chk("toggle high", 16'(d), 16'(h));
			chk("toggle low", 16'(d), 16'(l));
			rd(4'h3, v);
			chk("toggle flags", m ? 16'h0007 : 16'h0006, {12'h000, v[3:0]});
		end
		for (m = 5; m < 8; m++) begin
			init;
			top = (16'h0001 << (m + 3)) - 16'h0001;
			cmp = 16'($random(seed)) % top;
			inv = 1'($random(seed));
			wr(4'h0, 8'(m));
			wr16(4'h8, 16'hffff);
			rd(4'h9, v);
			chk("masked compare", top >> 8, {8'h00, v});
			wr16(4'h6, cmp);
			wr(4'h1, inv ? 8'h13 : 8'h12);
			wr(4'h2, 8'h01);
			meas;
			chk("pwm high", inv ? cmp + 16'h1 : top - cmp, 16'(h));
			chk("pwm low", inv ? top - cmp : cmp + 16'h1, 16'(l));
		end
		init;
		wr(4'h0, 8'h0c);
		wr16(4'h4, 16'hfff0);
		wr16(4'ha, 16'h0010);
		wr(4'h2, 8'h01);
		rd(4'h3, v);
		chk("flags before wrap", 16'h0000, {12'h000, v[3:0]});
		repeat (40) @(posedge clock);
		rd(4'h3, v);
		chk("flags after wrap", 16'h000f, {12'h000, v[3:0]});
		init;
		wr(4'h0, 8'h04);
		wr16(4'h6, 16'h0005);
		wr16(4'h4, 16'h0005);
		wr(4'h2, 8'h01);
		repeat (8) @(posedge clock);
		rd(4'h3, v);
		chk("blocked match", 16'h0000, {12'h000, v[3:0]});
		give_verdict;
	end
endmodule
